// *** verilog/adc_output_control_map.vh ***
// Contract
// - results clamp at plus or minus 15625
// - result is 15-bit two's complement, bit 14 sign
// - one result and interrupt per N samples
// - each result spans latest 2N samples
// - first two results after reconfiguration unsettled
// - short bit ties converter inputs together
// - clearing short bit restarts conversion and settling
// - rate field picks N, divider bit picks rate
// - rate codes divide by 125 up to 8000
// - sample rate is main clock over 25 or 50
// - enable bits start modulator and comb filter
// - upper two result bits carry the sign
`ifndef ADC_OUTPUT_CONTROL_MAP_VH
`define ADC_OUTPUT_CONTROL_MAP_VH

`define ADDR_W 8
`define CTRL_ADDR 8'h00
`define RESULT_ADDR 8'h04
`define STATUS_ADDR 8'h08

`define CTRL_SHORT_BIT 0
`define CTRL_MOD_EN_BIT 1
`define CTRL_GAIN_LSB 2
`define CTRL_GAIN_MSB 3
`define CTRL_RATE_LSB 4
`define CTRL_RATE_MSB 6
`define CTRL_DEC_EN_BIT 7
`define CTRL_DIV_SEL_BIT 8
`define CTRL_MUX_LSB 9
`define CTRL_MUX_MSB 15
`define CTRL_W 16
`define CTRL_RESET 16'h0000

`define STAT_SETTLED_BIT 0
`define STAT_FRESH_BIT 1

`define DIV_FAST 6'h19
`define DIV_SLOW 6'h32

`define BASE_SAMPLES 13'h07d
`define RATE_MAX_SHIFT 3'h6
`define SCALE_MULT 9'h07d
`define FULL_SCALE 15'h3d09
`define SETTLE_RESULTS 2'h2

`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0

`endif

// *** verilog/comb_decimator.v ***
`include "adc_output_control_map.vh"

module comb_decimator (
  input wire hclk,
  input wire hresetn,
  input wire sample_strobe,
  input wire modulator_bit,
  input wire restart,
  input wire [2:0] rate_code,
  output reg result_strobe,
  output reg [14:0] result_value
);
  reg [12:0] sample_cnt_reg;
  reg [13:0] ones_cur_reg;
  reg [13:0] ones_prev_reg;
  wire [2:0] shift;
  wire [12:0] window_len;
  wire [13:0] ones_cur_next;
  wire [13:0] total;
  wire signed [15:0] diff;
  wire signed [23:0] product;
  wire signed [23:0] shifted;
  wire signed [23:0] pos_limit;
  wire signed [23:0] neg_limit;
  wire [14:0] clamped;

  // codes 110 and 111 share the longest window
  assign shift = (rate_code > `RATE_MAX_SHIFT) ? `RATE_MAX_SHIFT : rate_code;
  assign window_len = `BASE_SAMPLES << shift;
  assign ones_cur_next = ones_cur_reg + {13'h0000, modulator_bit};
  // two adjacent windows of N make a 2N span overlapping by N
  assign total = ones_prev_reg + ones_cur_next;
  // ratio (ones-N)/N times full scale; full scale / 125 = 125
  assign diff = $signed({2'b00, total}) - $signed({3'b000, window_len});
  assign product = diff * $signed(`SCALE_MULT);
  assign shifted = product >>> shift;
  assign pos_limit = $signed({9'h000, `FULL_SCALE});
  assign neg_limit = -pos_limit;
  assign clamped = (shifted > pos_limit) ? `FULL_SCALE :
                   (shifted < neg_limit) ? (~`FULL_SCALE + 15'h0001) :
                   shifted[14:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_cnt_reg <= 13'h0000;
      ones_cur_reg <= 14'h0000;
      ones_prev_reg <= 14'h0000;
      result_strobe <= 1'b0;
      result_value <= 15'h0000;
    end else if (restart) begin
      sample_cnt_reg <= 13'h0000;
      ones_cur_reg <= 14'h0000;
      ones_prev_reg <= 14'h0000;
      result_strobe <= 1'b0;
    end else begin
      result_strobe <= 1'b0;
      if (sample_strobe) begin
        if (sample_cnt_reg == window_len - 13'h0001) begin
          sample_cnt_reg <= 13'h0000;
          ones_prev_reg <= ones_cur_next;
          ones_cur_reg <= 14'h0000;
          result_strobe <= 1'b1;
          result_value <= clamped;
        end else begin
          sample_cnt_reg <= sample_cnt_reg + 13'h0001;
          ones_cur_reg <= ones_cur_next;
        end
      end
    end
  end
endmodule // comb_decimator

// *** verilog/adc_output_control.v ***
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "adc_output_control_map.vh"

module adc_output_control (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [`ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire modulator_bit,
  output wire modulator_enable,
  output wire input_short_zero,
  output wire [1:0] input_gain_select,
  output wire [6:0] input_mux_select,
  output wire result_event
);
  // bus state
  reg wr_pending_reg;
  reg [`ADDR_W-1:0] wr_addr_reg;

  // configuration and results
  reg [`CTRL_W-1:0] ctrl_reg;
  reg [`CTRL_W-1:0] ctrl_next;
  reg [15:0] result_reg;
  reg [1:0] settle_cnt_reg;
  reg fresh_reg;
  reg cfg_change_reg;

  // modulator bitstream synchroniser
  reg bit_meta_reg;
  reg bit_sync_reg;

  // sample clock divider
  reg [5:0] div_cnt_reg;
  reg sample_strobe_reg;

  // next-state values
  reg [1:0] settle_cnt_next;
  reg fresh_next;
  reg [5:0] div_cnt_next;
  reg sample_strobe_next;

  wire addr_phase;
  wire rd_accept;
  wire ctrl_write;
  wire running;
  wire restart;
  wire [5:0] div_len;
  wire dec_strobe;
  wire [14:0] dec_value;
  wire settled;

  // zero wait states; every transfer answers okay
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;

  assign addr_phase = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];
  assign rd_accept = addr_phase & ~hwrite;
  assign ctrl_write = wr_pending_reg & (wr_addr_reg == `CTRL_ADDR);

  assign modulator_enable = ctrl_reg[`CTRL_MOD_EN_BIT];
  assign input_short_zero = ctrl_reg[`CTRL_SHORT_BIT];
  assign input_gain_select = ctrl_reg[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];
  assign input_mux_select = ctrl_reg[`CTRL_MUX_MSB:`CTRL_MUX_LSB];

  // the comb filter only runs behind a running modulator
  assign running = ctrl_reg[`CTRL_MOD_EN_BIT] & ctrl_reg[`CTRL_DEC_EN_BIT];
  assign restart = cfg_change_reg | ~running;

  assign div_len = ctrl_reg[`CTRL_DIV_SEL_BIT] ? `DIV_SLOW : `DIV_FAST;
  assign settled = (settle_cnt_reg == `SETTLE_RESULTS);
  assign result_event = dec_strobe;

  // write data arrives in the data phase, so latch the address first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= {`ADDR_W{1'b0}};
    end else begin
      wr_pending_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrl_write) begin
      ctrl_next = hwdata[`CTRL_W-1:0];
    end
  end

  // any changed field, short bit included, counts as a reconfiguration
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;
      cfg_change_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cfg_change_reg <= ctrl_write & (ctrl_next != ctrl_reg);
    end
  end

  // read data is registered at the address phase, one coherent snapshot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_accept) begin
      case (haddr)
        `CTRL_ADDR: begin
          hrdata <= {16'h0000, ctrl_reg};
        end
        `RESULT_ADDR: begin
          hrdata <= {16'h0000, result_reg};
        end
        `STATUS_ADDR: begin
          hrdata <= {30'h00000000, fresh_reg, settled};
        end
        default: begin
          hrdata <= 32'h00000000;
        end
      endcase
    end
  end

  // the bitstream comes from the analog side, outside this clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_meta_reg <= 1'b0;
      bit_sync_reg <= 1'b0;
    end else begin
      bit_meta_reg <= modulator_bit;
      bit_sync_reg <= bit_meta_reg;
    end
  end

  // one strobe per converter sample period
  // a divider switch also restarts, so restart clears the count, with no strobe, before >= can act
  always @* begin
    div_cnt_next = div_cnt_reg + 6'h01;
    sample_strobe_next = 1'b0;
    if (restart) begin
      div_cnt_next = 6'h00;
    end else if (div_cnt_reg >= div_len - 6'h01) begin
      div_cnt_next = 6'h00;
      sample_strobe_next = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 6'h00;
      sample_strobe_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      sample_strobe_reg <= sample_strobe_next;
    end
  end

  comb_decimator u_decimator (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_strobe(sample_strobe_reg),
    .modulator_bit(bit_sync_reg),
    .restart(restart),
    .rate_code(ctrl_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB]),
    .result_strobe(dec_strobe),
    .result_value(dec_value)
  );

  // held until the next result so a late read still sees one value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= 16'h0000;
    end else if (dec_strobe) begin
      result_reg <= {dec_value[14], dec_value};
    end
  end

  // count results since the last restart; two must pass before settled
  // the count stops at two so it never wraps back to unsettled
  always @* begin
    settle_cnt_next = settle_cnt_reg;
    if (restart) begin
      settle_cnt_next = 2'h0;
    end else if (dec_strobe && !settled) begin
      settle_cnt_next = settle_cnt_reg + 2'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt_reg <= 2'h0;
    end else begin
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // fresh flag: set by a result, cleared by reading the result word
  // a result landing in the clearing cycle keeps the flag set
  always @* begin
    fresh_next = fresh_reg;
    if (dec_strobe) begin
      fresh_next = 1'b1;
    end else if (rd_accept && haddr == `RESULT_ADDR) begin
      fresh_next = 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fresh_reg <= 1'b0;
    end else begin
      fresh_reg <= fresh_next;
    end
  end
endmodule // adc_output_control

// *** testbench/mod_source.sv ***
module mod_source (
  input wire logic hclk,
  input wire logic enable,
  input wire logic tied,
  input wire logic ones,
  output logic bit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt = 5'h0;
  logic alt = 1'h0;
  logic tick = 1'h0;
  always @(posedge hclk) begin
    tick <= ~tick;
    cnt <= cnt == 5'h18 ? 5'h0 : cnt + 5'h1;
    if (cnt == 5'h18)
      alt <= ~alt;
  end
  // stopped modulator gives no steady level; shorted inputs sit at half density
  assign bit_out = !enable ? tick : tied ? alt : ones;
endmodule // mod_source

// *** testbench/adc_output_control_monitor.sv ***
`include "adc_output_control_map.vh"
module adc_output_control_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [`ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire modulator_bit,
  input wire modulator_enable,
  input wire input_short_zero,
  input wire [1:0] input_gain_select,
  input wire [6:0] input_mux_select,
  input wire result_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc = hsel && hready && htrans[1];
  reg wr_q;
  reg rd_q;
  reg [12:0] gap;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      gap <= 13'h1fff;
    end else begin
      wr_q <= acc && hwrite && haddr == `CTRL_ADDR;
      rd_q <= acc && !hwrite && haddr == `RESULT_ADDR;
      gap <= result_event ? 13'h0 : (gap == 13'h1fff ? gap : gap + 13'h1);
    end
  end
  pulse_one_a: assert property (result_event |=> !result_event)
    else $error("long event");
  result_gap_a: assert property (result_event |-> gap >= 13'd3124)
    else $error("events too close");
  mod_en_a: assert property (wr_q |=> modulator_enable == $past(hwdata[1]))
    else $error("enable not taken");
  short_a: assert property (wr_q |=> input_short_zero == $past(hwdata[0]))
    else $error("short not taken");
  sel_a: assert property (wr_q |=> input_mux_select == $past(hwdata[15:9]))
    else $error("select not taken");
  gain_sel_a: assert property (wr_q |=> input_gain_select == $past(hwdata[3:2]))
    else $error("gain not taken");
  okay_resp_a: assert property (hreadyout && hresp == `HRESP_OKAY)
    else $error("bus answer not okay");
  idle_event_a: assert property (!modulator_enable [*3] |-> !result_event)
    else $error("event while idle");
  sign_ext_a: assert property (rd_q |-> hrdata[15] == hrdata[14])
    else $error("sign not extended");
  clamp_a: assert property (rd_q |-> hrdata[15:0] <= 16'h3d09 || hrdata[15:0] >= 16'hc2f7)
    else $error("result out of range");
  cover property (result_event && input_short_zero);
  cover property (rd_q && hrdata[15]);
  cover property ($fell(input_short_zero));
endmodule // adc_output_control_monitor
bind adc_output_control adc_output_control_monitor adc_output_control_monitor_inst (.*);

// *** testbench/tb_adc_output_control.sv ***
module tb_adc_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ones = 1'h1;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd, off;
  wire hready, hresp, mbit, men, tied, ev;
  wire [31:0] hrdata;
  int err_count = 0, samples_checked = 0, cyc = 0, t0;
  always #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  adc_output_control adc_output_control_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .modulator_bit(mbit), .modulator_enable(men), .input_short_zero(tied),
    .input_gain_select(), .input_mux_select(), .result_event(ev));
  mod_source mod_source_inst (.hclk(hclk), .enable(men), .tied(tied), .ones(ones),
    .bit_out(mbit));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // skips the two unsettled results, then times the third
  task automatic settle(input int gap);
    int k;
    repeat (3) begin
      if (k == 1) t0 = cyc;
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (ev !== 1'h1 && k < 7000);
      if (k < 7000) k = 1;
    end
    check(cyc - t0, gap);
  endtask
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #4ms;
    err_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 8'h00);
    check(rd, 32'h0);
    bus(1'h0, 8'h04);
    check(rd, 32'h0);
    bus(1'h1, 8'h0c, 32'hffff);
    bus(1'h0, 8'h0c);
    check(rd, 32'h0);
    bus(1'h1, 8'h00, 32'hfe8e);
    bus(1'h0, 8'h00);
    check(rd, 32'hfe8e);
    bus(1'h0, 8'h08);
    check(rd & 32'h1, 32'h0);
    settle(3125);
    bus(1'h0, 8'h04);
    check(rd, 32'h3d09);
    bus(1'h0, 8'h08);
    check(rd, 32'h1);
    bus(1'h0, 8'h04);
    check(rd, 32'h3d09);
    bus(1'h1, 8'h00, 32'h83);
    settle(3125);
    bus(1'h0, 8'h04);
    off = rd;
    check(rd, 32'h0);
    bus(1'h1, 8'h00, 32'h182);
    bus(1'h0, 8'h08);
    check(rd & 32'h1, 32'h0);
    settle(6250);
    bus(1'h0, 8'h08);
    check(rd, 32'h3);
    bus(1'h0, 8'h04);
    check(rd - off, 32'h3d09);
    ones <= 1'h0;
    bus(1'h1, 8'h00, 32'h96);
    bus(1'h0, 8'h08);
    check(rd & 32'h1, 32'h0);
    settle(6250);
    bus(1'h0, 8'h04);
    check(rd, 32'hc2f7);
    conclude();
  end
endmodule // tb_adc_output_control
